//--- apcms_far.sv
// Far-side model of the audio port pins and the divider clock sources
`timescale 1ns/100ps
`default_nettype none
module apcms_far (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and source ticks
  output logic [5:0] bclk_pin,
  output logic [5:0] fs_pin,
  output logic [3:0] tick
);
  logic [7:0] lfsr_q;
  logic [2:0] cnt_q;
  // sibling pin levels
  // Pins follow a free-running LFSR, so a stale or wrong pick shows up
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr_q <= 8'h5A;
      cnt_q <= 3'h0;
    end
    else
    begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign bclk_pin = lfsr_q[5:0];
  assign fs_pin = lfsr_q[7:2];
  // four source rates
  // Rates of one, a half, a quarter and an eighth of the bus clock
  assign tick = {cnt_q == 3'h0, cnt_q[1:0] == 2'h0, cnt_q[0], 1'b1};
endmodule
`default_nettype wire

//--- apcms_pkg.sv
// Constants and the fractional master clock divider for the audio port clock mode block
`timescale 1ns/100ps
`default_nettype none

package apcms_pkg;
  // Bus and register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_XFER_CFG_BASE = 8'h00;
  localparam logic [7:0] OFS_MCLK_CTRL_BASE = 8'h18;
  localparam logic [7:0] OFS_MCLK_DIV_BASE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam int NUM_DIR = 6;
  localparam int NUM_INST = 3;
  // Direction index is instance times two plus one for the receiver
  localparam logic [2:0] DIR_TX0 = 3'h0;
  localparam logic [2:0] DIR_RX0 = 3'h1;
  localparam logic [2:0] DIR_TX1 = 3'h2;
  localparam logic [2:0] DIR_RX1 = 3'h3;
  localparam logic [2:0] DIR_TX2 = 3'h4;
  localparam logic [2:0] DIR_RX2 = 3'h5;
  // Transfer config two fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_BCD_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [1:0] MODE_ASYNC_BUS = 2'h0;
  localparam logic [1:0] MODE_01 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] MODE_11 = 2'h3;
  // Master clock control fields
  localparam int MCR_SEL_LSB = 0;
  localparam int MCR_OE_BIT = 2;
  localparam logic [2:0] MCR_RESET = 3'h0;
  localparam logic [1:0] MASTER_CLOCK_INPUT_SELECT_IRC = 2'h0;
  localparam logic [1:0] MASTER_CLOCK_INPUT_SELECT_PLL_DIV = 2'h1;
  localparam logic [1:0] MASTER_CLOCK_INPUT_SELECT_MAIN_PLL = 2'h2;
  localparam logic [1:0] MASTER_CLOCK_INPUT_SELECT_XOSC = 2'h3;
  // Master clock divide fields
  localparam int MDR_DIV_LSB = 0;
  localparam int MDR_FRAC_LSB = 8;
  localparam logic [15:0] MDR_RESET = 16'h0000;
  // Status fields
  localparam int STAT_RSVD_LSB = 0;
  localparam int STAT_MCLK_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

module apcms_fcd #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Source ticks, indexed by input select code
  input wire logic [3:0] src_tick,
  // Settings
  input wire logic [1:0] input_sel,
  input wire logic out_en,
  input wire logic [DIV_W-1:0] divide,
  input wire logic [DIV_W-1:0] fraction,
  // Master clock
  output logic mclk,
  output logic mclk_rise
);
  typedef struct packed {
    logic [DIV_W:0] acc;
    logic mclk;
    logic rise;
  } apcms_fcd_t;

  apcms_fcd_t q, d;

  always_comb
  begin
    logic [DIV_W:0] sum;
    logic [DIV_W:0] frac;
    sum = '0;
    frac = (fraction > divide) ? {1'b0, divide} : {1'b0, fraction};
    d = q;
    d.rise = 1'b0;
    // Disabled divider restarts cleanly so a new setting takes effect from phase zero
    if (!out_en)
    begin
      d.acc = '0;
      d.mclk = 1'b0;
    end
    else if (src_tick[input_sel] && (divide != '0))
    begin
      sum = q.acc + frac;
      if (sum >= {1'b0, divide})
      begin
        d.acc = sum - {1'b0, divide};
        d.mclk = ~q.mclk;
        d.rise = ~q.mclk;
      end
      else
      begin
        d.acc = sum;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign mclk = q.mclk;
  assign mclk_rise = q.rise;

  src_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_en && !src_tick[input_sel]) |=> (q.acc == $past(q.acc) && !mclk_rise))
    else $error("Divider advanced without a tick from the selected source");
endmodule

`default_nettype wire

//--- apcms_top.sv
// Clock mode select for the transmit and receive sides of three audio serial ports
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Mode field meaning depends on bit-clock direction
// - Mode 00: asynchronous, or bus clock
// - Port 0 transmit: receiver, port 2 TX/RX
// - Port 1 transmit: receiver, port 2 TX/RX
// - Port 2: 01 own partner; 10/11 reserved
// - Port 0 receive: transmitter, port 2 RX/TX
// - Port 1 receive: transmitter, port 2 RX/TX
// - Input select picks one of four sources
// - Only port 2 masters other ports' external bit clocks; master clocks of ports 0, 1 and 2 are shared
module apcms_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite write
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [apcms_pkg::ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [apcms_pkg::ADDR_W-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Divider source ticks
  input wire logic INTERNAL_RC_OSC_CLOCK_TICK,
  input wire logic PLL_DIV_CLOCK_TICK,
  input wire logic MAIN_PLL_CLOCK_TICK,
  input wire logic CRYSTAL_OSC_CLOCK_TICK,
  // Port pins per direction
  input wire logic [5:0] BCLK_PIN,
  input wire logic [5:0] FS_PIN,
  // Selected clocking per direction, master clock per port
  output logic [5:0] BCLK_OUT,
  output logic [5:0] FS_OUT,
  output logic [5:0] BCLK_EN_OUT,
  output logic [2:0] MCLK_OUT
);
  typedef struct packed {
    logic [5:0][2:0] cfg;
    logic [2:0][2:0] mcr;
    logic [2:0][15:0] mdr;
    logic aw_have;
    logic [apcms_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] bclk;
    logic [5:0] fs;
    logic [5:0] tick;
  } apcms_state_t;

  apcms_state_t r_q, r_d;
  logic [2:0] mclk_lvl;
  logic [2:0] mclk_rise;
  logic [3:0] src_tick;
  logic [5:0] rsvd;

  // Order follows the input select encoding
  assign src_tick = {CRYSTAL_OSC_CLOCK_TICK, MAIN_PLL_CLOCK_TICK,
                     PLL_DIV_CLOCK_TICK, INTERNAL_RC_OSC_CLOCK_TICK};

  // Sync partner for an external bit clock; bit 3 set means none
  function automatic logic [3:0] sync_partner(input logic [2:0] dir, input logic [1:0] m);
    logic [3:0] p;
    p = 4'h8;
    case (dir)
      apcms_pkg::DIR_TX0:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_RX0} :
            (m == apcms_pkg::MODE_10) ? {1'b0, apcms_pkg::DIR_TX2} :
            (m == apcms_pkg::MODE_11) ? {1'b0, apcms_pkg::DIR_RX2} : 4'h8;
      apcms_pkg::DIR_TX1:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_RX1} :
            (m == apcms_pkg::MODE_10) ? {1'b0, apcms_pkg::DIR_TX2} :
            (m == apcms_pkg::MODE_11) ? {1'b0, apcms_pkg::DIR_RX2} : 4'h8;
      apcms_pkg::DIR_RX0:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_TX0} :
            (m == apcms_pkg::MODE_10) ? {1'b0, apcms_pkg::DIR_RX2} :
            (m == apcms_pkg::MODE_11) ? {1'b0, apcms_pkg::DIR_TX2} : 4'h8;
      apcms_pkg::DIR_RX1:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_TX1} :
            (m == apcms_pkg::MODE_10) ? {1'b0, apcms_pkg::DIR_RX2} :
            (m == apcms_pkg::MODE_11) ? {1'b0, apcms_pkg::DIR_TX2} : 4'h8;
      // port 2 only pairs with itself
      apcms_pkg::DIR_TX2:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_RX2} : 4'h8;
      apcms_pkg::DIR_RX2:
        p = (m == apcms_pkg::MODE_01) ? {1'b0, apcms_pkg::DIR_TX2} : 4'h8;
      default:
        p = 4'h8;
    endcase
    return p;
  endfunction

  // Master clock for an internal bit clock; 3 means bus clock
  function automatic logic [1:0] mclk_pick(input logic [1:0] inst, input logic [1:0] m);
    logic [1:0] s;
    s = 2'h3;
    case (m)
      apcms_pkg::MODE_01: s = inst;
      apcms_pkg::MODE_10: s = (inst == 2'h0) ? 2'h1 : 2'h0;
      apcms_pkg::MODE_11: s = (inst == 2'h2) ? 2'h1 : 2'h2;
      default: s = 2'h3;
    endcase
    return s;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < apcms_pkg::NUM_INST; gi++)
    begin : g_fcd
      apcms_fcd #(.DIV_W(DIV_W)) u_fcd (
        .clk(CLK),
        .rst_n(RSTN),
        .src_tick(src_tick),
        .input_sel(r_q.mcr[gi][apcms_pkg::MCR_SEL_LSB +: 2]),
        .out_en(r_q.mcr[gi][apcms_pkg::MCR_OE_BIT]),
        .divide(r_q.mdr[gi][apcms_pkg::MDR_DIV_LSB +: DIV_W]),
        .fraction(r_q.mdr[gi][apcms_pkg::MDR_FRAC_LSB +: DIV_W]),
        .mclk(mclk_lvl[gi]),
        .mclk_rise(mclk_rise[gi])
      );
    end
  endgenerate

  always_comb
  begin
    logic [3:0] p;
    logic [1:0] s;
    logic [1:0] m;
    logic [5:0] widx;
    logic [5:0] ridx;
    p = '0;
    s = '0;
    m = '0;
    widx = r_q.aw_addr[apcms_pkg::ADDR_W-1:2];
    ridx = ARADDR[apcms_pkg::ADDR_W-1:2];
    r_d = r_q;
    rsvd = '0;
    for (int i = 0; i < apcms_pkg::NUM_DIR; i++)
    begin
      m = r_q.cfg[i][apcms_pkg::CFG_MODE_LSB +: 2];
      if (r_q.cfg[i][apcms_pkg::CFG_BCD_BIT])
      begin
        s = mclk_pick(2'(i / 2), m);
        r_d.tick[i] = (s == 2'h3) ? 1'b1 : mclk_rise[s];
        r_d.bclk[i] = 1'b0;
        r_d.fs[i] = FS_PIN[i];
      end
      else
      begin
        p = sync_partner(3'(i), m);
        // reserved codes fall back to own pins
        rsvd[i] = (i >= 4) && (m[1] == 1'b1);
        r_d.tick[i] = 1'b0;
        r_d.bclk[i] = p[3] ? BCLK_PIN[i] : BCLK_PIN[p[2:0]];
        r_d.fs[i] = p[3] ? FS_PIN[i] : FS_PIN[p[2:0]];
      end
    end
    // Write channel, address and data taken in either order
    if (AWVALID && r_q.awready)
    begin
      r_d.aw_have = 1'b1;
      r_d.aw_addr = AWADDR;
    end
    if (WVALID && r_q.wready)
    begin
      r_d.w_have = 1'b1;
      r_d.w_data = WDATA;
      r_d.w_strb = WSTRB;
    end
    if (BVALID && BREADY)
      r_d.bvalid = 1'b0;
    if (r_q.aw_have && r_q.w_have && !r_q.bvalid)
    begin
      r_d.aw_have = 1'b0;
      r_d.w_have = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = apcms_pkg::RESP_OKAY;
      if (widx < 6'(apcms_pkg::NUM_DIR))
      begin
        if (r_q.w_strb[0])
          r_d.cfg[widx] = r_q.w_data[2:0];
      end
      else if (widx >= 6'(apcms_pkg::OFS_MCLK_CTRL_BASE >> 2) &&
               widx < 6'((apcms_pkg::OFS_MCLK_CTRL_BASE >> 2) + 3))
      begin
        if (r_q.w_strb[0])
          r_d.mcr[widx - 6'(apcms_pkg::OFS_MCLK_CTRL_BASE >> 2)] = r_q.w_data[2:0];
      end
      else if (widx >= 6'(apcms_pkg::OFS_MCLK_DIV_BASE >> 2) &&
               widx < 6'((apcms_pkg::OFS_MCLK_DIV_BASE >> 2) + 3))
      begin
        for (int b = 0; b < 2; b++)
          if (r_q.w_strb[b])
            r_d.mdr[widx - 6'(apcms_pkg::OFS_MCLK_DIV_BASE >> 2)][b*8 +: 8] =
              r_q.w_data[b*8 +: 8];
      end
      else if (widx != 6'(apcms_pkg::OFS_STATUS >> 2))
        r_d.bresp = apcms_pkg::RESP_SLVERR;
    end
    r_d.awready = !r_d.aw_have && !r_d.bvalid;
    r_d.wready = !r_d.w_have && !r_d.bvalid;
    // Read channel answers on the same edge that takes the address
    if (RVALID && RREADY)
      r_d.rvalid = 1'b0;
    if (ARVALID && r_q.arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rdata = '0;
      r_d.rresp = apcms_pkg::RESP_OKAY;
      if (ridx < 6'(apcms_pkg::NUM_DIR))
        r_d.rdata[2:0] = r_q.cfg[ridx];
      else if (ridx >= 6'(apcms_pkg::OFS_MCLK_CTRL_BASE >> 2) &&
               ridx < 6'((apcms_pkg::OFS_MCLK_CTRL_BASE >> 2) + 3))
        r_d.rdata[2:0] = r_q.mcr[ridx - 6'(apcms_pkg::OFS_MCLK_CTRL_BASE >> 2)];
      else if (ridx >= 6'(apcms_pkg::OFS_MCLK_DIV_BASE >> 2) &&
               ridx < 6'((apcms_pkg::OFS_MCLK_DIV_BASE >> 2) + 3))
        r_d.rdata[15:0] = r_q.mdr[ridx - 6'(apcms_pkg::OFS_MCLK_DIV_BASE >> 2)];
      else if (ridx == 6'(apcms_pkg::OFS_STATUS >> 2))
      begin
        r_d.rdata[apcms_pkg::STAT_RSVD_LSB +: 6] = rsvd;
        r_d.rdata[apcms_pkg::STAT_MCLK_LSB +: 3] = mclk_lvl;
      end
      else
        r_d.rresp = apcms_pkg::RESP_SLVERR;
    end
    r_d.arready = !r_d.rvalid;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      r_q <= '0;
      r_q.cfg <= {apcms_pkg::NUM_DIR{apcms_pkg::CFG_RESET}};
      r_q.mcr <= {apcms_pkg::NUM_INST{apcms_pkg::MCR_RESET}};
      r_q.mdr <= {apcms_pkg::NUM_INST{apcms_pkg::MDR_RESET}};
      r_q.awready <= 1'b1;
      r_q.wready <= 1'b1;
      r_q.arready <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign AWREADY = r_q.awready;
  assign WREADY = r_q.wready;
  assign BVALID = r_q.bvalid;
  assign BRESP = r_q.bresp;
  assign ARREADY = r_q.arready;
  assign RVALID = r_q.rvalid;
  assign RDATA = r_q.rdata;
  assign RRESP = r_q.rresp;
  assign BCLK_OUT = r_q.bclk;
  assign FS_OUT = r_q.fs;
  assign BCLK_EN_OUT = r_q.tick;
  assign MCLK_OUT = mclk_lvl;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  dir_split_a: assert property (r_q.cfg[0][2] |=> (BCLK_OUT[0] == 1'b0))
    else $error("Internal bit clock still passes the external pin");
  bus_tick_a: assert property ((r_q.cfg[3] == 3'h4) |=> BCLK_EN_OUT[3] [*1])
    else $error("Bus clock selection did not tick every cycle");
  tx0_sync_a: assert property ((r_q.cfg[0] == 3'h2) |=> (BCLK_OUT[0] == $past(BCLK_PIN[4])))
    else $error("Port 0 transmit not following port 2 transmit clock");
  tx1_mclk_a: assert property ((r_q.cfg[2] == 3'h6) |=> (BCLK_EN_OUT[2] == $past(mclk_rise[0])))
    else $error("Port 1 transmit not ticking from port 0 master clock");
  port2_rsvd_a: assert property ((r_q.cfg[4][2:1] == 2'h1) |=> (BCLK_OUT[4] == $past(BCLK_PIN[4])))
    else $error("Port 2 reserved code took a foreign clock");
  rx0_sync_a: assert property ((r_q.cfg[1] == 3'h3) |=> (FS_OUT[1] == $past(FS_PIN[4])))
    else $error("Port 0 receive not following port 2 transmit sync");
  rx1_sync_a: assert property ((r_q.cfg[3] == 3'h2) |=> (BCLK_OUT[3] == $past(BCLK_PIN[5])))
    else $error("Port 1 receive not following port 2 receive clock");
  port2_master_a: assert property ((r_q.cfg[5] == 3'h0) ##1 (r_q.cfg[5] == 3'h0) |=> (FS_OUT[5] == $past(FS_PIN[5]) && BCLK_OUT[5] == $past(BCLK_PIN[5])))
    else $error("Port 2 receive slaved to another port");
  own_partner_a: assert property ((r_q.cfg[2] == 3'h1) |=> (FS_OUT[2] == $past(FS_PIN[3]) && BCLK_OUT[2] == $past(BCLK_PIN[3])))
    else $error("Port 1 transmit not using its receiver clock and sync");

  sync_chain_c: cover property ((r_q.cfg[1] == 3'h2) && (r_q.cfg[3] == 3'h2));
  mclk_run_c: cover property (r_q.mcr[2][2] && mclk_rise[2]);
  write_done_c: cover property (BVALID && BREADY);
  read_done_c: cover property (RVALID && RREADY && (RRESP == apcms_pkg::RESP_OKAY));
endmodule

`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the audio port clock mode block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [5:0] BCLK_PIN, FS_PIN, BCLK_OUT, FS_OUT, BCLK_EN_OUT;
  logic [3:0] tick;
  logic [2:0] MCLK_OUT;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  // Source direction per direction and mode, external bit clock
  int src_t [6][4] = '{'{0, 1, 4, 5}, '{1, 0, 5, 4}, '{2, 3, 4, 5},
    '{3, 2, 5, 4}, '{4, 5, 4, 4}, '{5, 4, 5, 5}};
  // Master clock instance per direction and mode, internal bit clock
  int mi_t [6][4] = '{'{0, 0, 1, 2}, '{0, 0, 1, 2}, '{0, 1, 0, 2},
    '{0, 1, 0, 2}, '{0, 2, 0, 1}, '{0, 2, 0, 1}};
  // Master clock rises in 64 cycles for sources 00, 01 and 11
  int rise_t [3] = '{32, 16, 4};

  always #4 CLK = ~CLK;

  apcms_top #(.DIV_W(8)) uut (
    .CLK, .RSTN, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY,
    .RDATA, .RRESP, .INTERNAL_RC_OSC_CLOCK_TICK(tick[0]), .PLL_DIV_CLOCK_TICK(tick[1]),
    .MAIN_PLL_CLOCK_TICK(tick[2]), .CRYSTAL_OSC_CLOCK_TICK(tick[3]), .BCLK_PIN,
    .FS_PIN, .BCLK_OUT, .FS_OUT, .BCLK_EN_OUT, .MCLK_OUT
  );
  apcms_far far (.clk(CLK), .rst_n(RSTN), .bclk_pin(BCLK_PIN), .fs_pin(FS_PIN), .tick(tick));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Counts of clock edges may slip by one at the window ends
  task automatic chk_near(input string n, input int e, input int g);
    compares++;
    if (g < e - 1 || g > e + 1)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit wd;
    aw = 0;
    wd = 0;
    @(posedge CLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hF;
    BREADY <= 1'b1;
    while (!(aw && wd))
    begin
      @(posedge CLK);
      if (AWVALID && AWREADY)
      begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        wd = 1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge CLK); while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic mclk_setup(input int i, input logic [1:0] s);
    logic [1:0] r;
    wr(apcms_pkg::OFS_MCLK_CTRL_BASE + 8'(i * 4), {30'h0, s}, r);
    wr(apcms_pkg::OFS_MCLK_DIV_BASE + 8'(i * 4), 32'h0101, r);
    wr(apcms_pkg::OFS_MCLK_CTRL_BASE + 8'(i * 4), {29'h0, 1'b1, s}, r);
  endtask

  task automatic count(input int i, input int dd, output int nm, output int ne);
    logic p;
    nm = 0;
    ne = 0;
    p = MCLK_OUT[i];
    repeat (64)
    begin
      @(negedge CLK);
      if (MCLK_OUT[i] === 1'b1 && p === 1'b0)
        nm++;
      p = MCLK_OUT[i];
      if (BCLK_EN_OUT[dd] === 1'b1)
        ne++;
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [5:0] pb;
    logic [5:0] pf;
    int cm;
    int ce;
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    for (int a = 0; a < 13; a++)
    begin
      rd(8'(a * 4), d, r);
      chk("reset value", 32'h0, d);
    end
    rd(8'h34, d, r);
    chk("unmapped read", {30'h0, apcms_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h34, 32'h7, r);
    chk("unmapped write", {30'h0, apcms_pkg::RESP_SLVERR}, {30'h0, r});
    for (int dd = 0; dd < 6; dd++)
      for (int m = 0; m < 4; m++)
      begin
        wr(8'(dd * 4), 32'(m), r);
        repeat (2) @(negedge CLK);
        repeat (6)
        begin
          @(negedge CLK);
          pb = BCLK_PIN;
          pf = FS_PIN;
          @(negedge CLK);
          chk("bclk source", pb[src_t[dd][m]], BCLK_OUT[dd]);
          chk("fs source", pf[src_t[dd][m]], FS_OUT[dd]);
          chk("bclk enable", 1'b0, BCLK_EN_OUT[dd]);
        end
        rd(apcms_pkg::OFS_STATUS, d, r);
        chk("reserved flag", 32'(dd >= 4 && m >= 2) << dd, d & 32'h3F);
        wr(8'(dd * 4), 32'h0, r);
      end
    for (int k = 0; k < 4; k++)
    begin
      mclk_setup(0, 2'(k));
      repeat (4) @(negedge CLK);
      count(0, 0, cm, ce);
      chk_near("mclk rises", 32 >> k, cm);
    end
    rd(apcms_pkg::OFS_MCLK_DIV_BASE, d, r);
    chk("divide readback", 32'h0101, d);
    wr(apcms_pkg::OFS_MCLK_CTRL_BASE, 32'h0, r);
    repeat (2) @(negedge CLK);
    count(0, 0, cm, ce);
    chk("mclk disabled", 32'h0, 32'(cm));
    mclk_setup(0, 2'h0);
    mclk_setup(1, 2'h1);
    mclk_setup(2, 2'h3);
    for (int dd = 0; dd < 6; dd++)
      for (int m = 0; m < 4; m++)
      begin
        wr(8'(dd * 4), 32'(4 + m), r);
        repeat (3) @(negedge CLK);
        count(mi_t[dd][m], dd, cm, ce);
        if (m == 0)
          chk("bus clock enable", 32'd64, 32'(ce));
        else
          chk_near("mclk enable", rise_t[mi_t[dd][m]], ce);
        chk("bclk internal", 1'b0, BCLK_OUT[dd]);
        wr(8'(dd * 4), 32'h0, r);
      end
    wrap_up();
  end
endmodule
`default_nettype wire
